/* core/fswp_top.sv */
// status and configuration register write with write protection.
// assumes serial pins arrive asynchronously and are much slower than mclk;
// program/erase requests and the region hit come from logic on mclk.
//
// Behaviour
// [RULE1] drive strength code maps to 90/60/45/20/15/30 ohms; 000 and 100 reserved
// [RULE2] dummy field picks dummy clocks per read family as tabled
// [RULE3] write-status acts only if write enable latch was set before
// [RULE4] write-status writes protect, quad and disable bits, never latch or busy
// [RULE5] hardware protection mode refuses write-status
// [RULE6] host frames chip select low, opcode, data, chip select high
// [RULE7] chip select must rise after exactly 8 or 16 data bits, else reject
// [RULE8] register write cycle starts when chip select rises on a valid command
// [RULE9] busy reads 1 during the write, then 0 and latch cleared
// [RULE10] disable bit 0: latch settable, protect bits writable at any pin level
// [RULE11] disable bit 1 with pin high: still writable, software protection
// [RULE12] disable bit 1 with pin low: every status write rejected
// [RULE13] hardware protection when disable bit 1 and pin low, either order
// [RULE14] hardware protection ends only when the pin goes high; here four-wire command mode ends it too, with the pin still low
// [RULE15] four-wire mode or quad enable disables hardware protection
// [RULE16] program and erase refused inside the protected region
// [RULE17] hardware protection keeps disable and protect bits fixed
// [RULE18] host keeps protect pin high until a write finishes
// [RULE19] dummy field sits in configuration bits 7 and 6
// [RULE20] quad enable 0 ignores quad commands; shared pin is protect input
// [RULE21] top/bottom bit one-time programmable, 0 top, 1 bottom
// [RULE22] two data bytes: first to status, second to configuration
`timescale 1ns/1ps
`default_nettype none
`include "fswp_cfg.svh"

module fswp_top #(
  parameter int TW_CYCLES = `FSWP_TW_CYC
) (
  input  wire logic                   mclk,
  input  wire logic                   nrst,
  input  wire logic                   cs_n,
  input  wire logic                   sclk,
  input  wire logic                   si,
  input  wire logic                   write_protect_n_io2,
  input  wire logic                   four_wire_cmd_mode,
  input  wire logic                   pe_req,
  input  wire logic                   pe_region_hit,
  output var  fswp_pkg::fswp_status_t status_q,
  output var  fswp_pkg::fswp_config_t config_q,
  output var  logic                   hardware_protect_mode_q,
  output var  logic                   software_protect_mode_q,
  output var  logic                   quad_cmds_enabled_q,
  output var  logic                   write_status_cmd_reject_q,
  output var  logic                   pe_accept_q,
  output var  logic                   pe_reject_q,
  output var  logic [6:0]             ods_ohms_q,
  output var  logic                   ods_reserved_q,
  output var  logic [3:0]             dummy_out_q,
  output var  logic [3:0]             dummy_dio_q,
  output var  logic [3:0]             dummy_qio_q
);

  // pin indices inside the synchroniser vector
  localparam int PIN_CS = 3;
  localparam int PIN_CK = 2;
  localparam int PIN_SI = 1;
  localparam int PIN_WP = 0;

  // ==========================================================
  // decode functions
  function automatic logic [6:0] ods_ohms(input logic [2:0] code);
    unique case (code)
      3'h1:    ods_ohms = 7'h5A;
      3'h2:    ods_ohms = 7'h3C;
      3'h3:    ods_ohms = 7'h2D;
      3'h5:    ods_ohms = 7'h14;
      3'h6:    ods_ohms = 7'h0F;
      3'h7:    ods_ohms = 7'h1E;
      default: ods_ohms = 7'h00;
    endcase
  endfunction

  function automatic logic [3:0] dummy_cnt(input logic [1:0] dc,
                                           input fswp_pkg::fswp_read_fam_t fam);
    unique case (dc)
      2'h0: begin
        if (fam == fswp_pkg::FSWP_FAM_OUT) dummy_cnt = 4'h8;
        else if (fam == fswp_pkg::FSWP_FAM_DIO) dummy_cnt = 4'h4;
        else dummy_cnt = 4'h6;
      end
      2'h1: begin
        if (fam == fswp_pkg::FSWP_FAM_QIO) dummy_cnt = 4'h4;
        else dummy_cnt = 4'h6;
      end
      2'h2:    dummy_cnt = 4'h8;
      2'h3:    dummy_cnt = 4'hA;
    endcase
  endfunction

  // ==========================================================
  // synchronisers; the first stage feeds only the second
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic       cs_d_q;
  logic       ck_d_q;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pin_s1_q <= 4'hF;
      pin_s2_q <= 4'hF;
      cs_d_q   <= 1'b1;
      ck_d_q   <= 1'b0;
    end else begin
      pin_s1_q <= {cs_n, sclk, si, write_protect_n_io2};
      pin_s2_q <= pin_s1_q;
      cs_d_q   <= pin_s2_q[PIN_CS];
      ck_d_q   <= pin_s2_q[PIN_CK];
    end
  end

  logic cs_rise;
  logic ck_rise;
  logic wp_s;
  assign cs_rise = pin_s2_q[PIN_CS] & ~cs_d_q;
  assign ck_rise = pin_s2_q[PIN_CK] & ~ck_d_q & ~pin_s2_q[PIN_CS];
  // shared pin only acts as protect input while quad mode is off
  assign wp_s    = pin_s2_q[PIN_WP] | status_q.qe;                          // RULE20

  // ==========================================================
  // serial shifter; bits are taken on serial clock rising edges
  logic [4:0]  bit_cnt_q;
  logic [23:0] shift_q;
  logic [7:0]  op_q;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bit_cnt_q <= 5'h00;
      shift_q   <= 24'h000000;
      op_q      <= 8'h00;
    end else if (pin_s2_q[PIN_CS]) begin
      bit_cnt_q <= 5'h00;                                                  // RULE6
      op_q      <= 8'h00;
    end else if (ck_rise) begin
      shift_q <= {shift_q[22:0], pin_s2_q[PIN_SI]};
      if (bit_cnt_q != `FSWP_BITS_MAX) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
      if (bit_cnt_q == `FSWP_BITS_OP - 5'h01) begin
        op_q <= {shift_q[6:0], pin_s2_q[PIN_SI]};
      end
    end
  end

  // ==========================================================
  // command decode at the end of a frame
  fswp_pkg::fswp_state_t state_q;
  logic busy;
  logic write_status_cmd_frame;
  logic write_status_cmd_len_ok;
  logic wr_start;
  logic write_enable_cmd_go;
  logic wr_done;
  logic pe_rej;

  assign busy        = (state_q == fswp_pkg::FSWP_WRITE);
  assign write_status_cmd_frame  = cs_rise & (op_q == `FSWP_OP_WRITE_STATUS)
                       & (bit_cnt_q >= `FSWP_BITS_OP);
  assign write_status_cmd_len_ok = (bit_cnt_q == `FSWP_BITS_ONE)
                       | (bit_cnt_q == `FSWP_BITS_TWO);                    // RULE7
  // latch needed, hardware protection refuses, bad length refuses
  assign wr_start    = write_status_cmd_frame & write_status_cmd_len_ok & ~busy & status_q.write_enable_latch     // RULE3
                       & ~hardware_protect_mode_q;                         // RULE5 RULE12 RULE17
  // the latch may be set whatever the disable bit and pin show
  assign write_enable_cmd_go     = cs_rise & ~busy & (bit_cnt_q == `FSWP_BITS_OP)
                       & (op_q == `FSWP_OP_WRITE_ENABLE);                  // RULE10 RULE11
  assign pe_rej      = pe_req & ~busy & status_q.write_enable_latch & pe_region_hit;

  // ==========================================================
  // engine state: idle until a valid write starts, then timed
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= fswp_pkg::FSWP_IDLE;
    end else begin
      unique case (state_q)
        fswp_pkg::FSWP_IDLE: begin
          if (wr_start) state_q <= fswp_pkg::FSWP_WRITE;                   // RULE8
        end
        fswp_pkg::FSWP_WRITE: begin
          if (wr_done) state_q <= fswp_pkg::FSWP_IDLE;
        end
      endcase
    end
  end

  fswp_wtimer #(
    .CYCLES (TW_CYCLES)
  ) u_wtimer (
    .mclk   (mclk),
    .nrst   (nrst),
    .start  (wr_start),
    .done_q (wr_done)
  );

  // ==========================================================
  // pending data, held until the timed write completes
  fswp_pkg::fswp_status_t pend_st_q;
  fswp_pkg::fswp_config_t pend_cfg_q;
  logic                   pend_two_q;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pend_st_q  <= fswp_pkg::fswp_status_t'(`FSWP_SR_RST);
      pend_cfg_q <= fswp_pkg::fswp_config_t'(`FSWP_CR_RST);
      pend_two_q <= 1'b0;
    end else if (wr_start) begin
      pend_two_q <= (bit_cnt_q == `FSWP_BITS_TWO);
      if (bit_cnt_q == `FSWP_BITS_TWO) begin
        pend_st_q  <= fswp_pkg::fswp_status_t'(shift_q[15:8]);             // RULE22
        pend_cfg_q <= fswp_pkg::fswp_config_t'(shift_q[7:0]);
      end else begin
        pend_st_q  <= fswp_pkg::fswp_status_t'(shift_q[7:0]);
      end
    end
  end

  // ==========================================================
  // status register; latch and busy never come from written data
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      status_q <= fswp_pkg::fswp_status_t'(`FSWP_SR_RST);
    end else if (wr_done) begin
      status_q.status_write_disable <= pend_st_q.status_write_disable;                                     // RULE4
      status_q.qe   <= pend_st_q.qe;
      status_q.bp   <= pend_st_q.bp;
      status_q.write_in_progress  <= 1'b0;                                               // RULE9
      status_q.write_enable_latch  <= 1'b0;
    end else if (wr_start) begin
      status_q.write_in_progress <= 1'b1;                                                // RULE9
    end else if (write_enable_cmd_go) begin
      status_q.write_enable_latch <= 1'b1;                                                // RULE10
    end else if (pe_rej) begin
      status_q.write_enable_latch <= 1'b0;
    end
  end

  // ==========================================================
  // configuration register; top/bottom can only go from 0 to 1
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      config_q <= fswp_pkg::fswp_config_t'(`FSWP_CR_RST);
    end else if (wr_done && pend_two_q) begin
      config_q.dc  <= pend_cfg_q.dc;                                       // RULE22
      config_q.pbe <= pend_cfg_q.pbe;
      config_q.drive_strength_sel <= pend_cfg_q.drive_strength_sel;
      config_q.tb  <= config_q.tb | pend_cfg_q.tb;                         // RULE21
    end
  end

  // ==========================================================
  // protection modes; pin level and disable bit combine in any order
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hardware_protect_mode_q <= 1'b0;
      software_protect_mode_q <= 1'b1;
      quad_cmds_enabled_q     <= 1'b0;
      write_status_cmd_reject_q           <= 1'b0;
    end else begin
      hardware_protect_mode_q <= status_q.status_write_disable & ~wp_s                     // RULE13 RULE14
                                 & ~four_wire_cmd_mode;                    // RULE15
      software_protect_mode_q <= ~(status_q.status_write_disable & ~wp_s & ~four_wire_cmd_mode);
      quad_cmds_enabled_q     <= status_q.qe;                              // RULE20
      write_status_cmd_reject_q           <= write_status_cmd_frame & ~wr_start;
    end
  end

  // ==========================================================
  // program/erase gate; a refused request also drops the latch
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pe_accept_q <= 1'b0;
      pe_reject_q <= 1'b0;
    end else begin
      pe_accept_q <= pe_req & ~busy & status_q.write_enable_latch & ~pe_region_hit;
      pe_reject_q <= pe_rej;                                               // RULE16
    end
  end

  // ==========================================================
  // decoded configuration for the output and read paths
  logic [1:0] dc_sel;
  assign dc_sel = config_q[`FSWP_CR_DC_HI:`FSWP_CR_DC_LO];                // RULE19

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ods_ohms_q     <= 7'h00;
      ods_reserved_q <= 1'b0;
      dummy_out_q    <= 4'h0;
      dummy_dio_q    <= 4'h0;
      dummy_qio_q    <= 4'h0;
    end else begin
      ods_ohms_q     <= ods_ohms(config_q.drive_strength_sel);                            // RULE1
      ods_reserved_q <= (config_q.drive_strength_sel[1:0] == 2'h0);
      dummy_out_q    <= dummy_cnt(dc_sel, fswp_pkg::FSWP_FAM_OUT);         // RULE2
      dummy_dio_q    <= dummy_cnt(dc_sel, fswp_pkg::FSWP_FAM_DIO);
      dummy_qio_q    <= dummy_cnt(dc_sel, fswp_pkg::FSWP_FAM_QIO);
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence wip_run_s;
    status_q.write_in_progress [*8];
  endsequence

  sequence write_done_s;
    wr_done ##1 (!status_q.write_in_progress && !status_q.write_enable_latch);
  endsequence

  wel_needed_a: assert property ( // RULE3
    wr_start |-> status_q.write_enable_latch && $past(status_q.write_enable_latch))
    else $error("write started without latch");
  keep_bits_a: assert property ( // RULE4
    wr_done |=> status_q.bp == $past(pend_st_q.bp) && status_q.status_write_disable == $past(pend_st_q.status_write_disable))
    else $error("status fields not committed");
  hpm_refuse_a: assert property ( // RULE5
    (cs_rise && hardware_protect_mode_q) |-> !wr_start)
    else $error("write accepted under hardware protection");
  bad_count_a: assert property ( // RULE7
    (cs_rise && !busy && !write_status_cmd_len_ok) |=> !busy)
    else $error("odd length frame started a write");
  wip_hold_a: assert property ( // RULE9
    wr_start |=> wip_run_s)
    else $error("busy flag dropped early");
  done_clear_a: assert property ( // RULE9
    wr_done |-> write_done_s)
    else $error("busy or latch left set");
  hpm_enter_a: assert property ( // RULE13
    (status_q.status_write_disable && !wp_s && !four_wire_cmd_mode) |=> hardware_protect_mode_q)
    else $error("hardware protection not entered");
  hpm_off_a: assert property ( // RULE15
    (status_q.qe || four_wire_cmd_mode) |=> !hardware_protect_mode_q)
    else $error("hardware protection despite quad or four-wire");
  pe_refuse_a: assert property ( // RULE16
    (pe_req && pe_region_hit) |=> !pe_accept_q)
    else $error("protected region program accepted");
  tb_otp_a: assert property ( // RULE21
    config_q.tb |=> config_q.tb)
    else $error("top bottom bit cleared");
  ods_map_a: assert property ( // RULE1
    $past(nrst) && $past(config_q.drive_strength_sel) == 3'h1 |-> ods_ohms_q == 7'h5A)
    else $error("drive strength decode wrong");
  dc_map_a: assert property ( // RULE2
    $past(nrst) && $past(dc_sel) == 2'h0 |-> dummy_out_q == 4'h8 && dummy_dio_q == 4'h4)
    else $error("dummy decode wrong");

endmodule

`default_nettype wire

/* core/fswp_cfg.svh */
// constants of the status-write and write-protect block: opcodes, frame
// lengths, field positions, reset values and the register write time.
// assumes a 20 MHz system clock; included by the top, the write timer and the bench.
`ifndef FSWP_CFG_SVH
`define FSWP_CFG_SVH

// ==========================================================
// command opcodes
`define FSWP_OP_WRITE_STATUS 8'h01
`define FSWP_OP_WRITE_ENABLE 8'h06

// ==========================================================
// frame lengths in serial bits, opcode included
`define FSWP_BITS_OP         5'h08
`define FSWP_BITS_ONE        5'h10
`define FSWP_BITS_TWO        5'h18
`define FSWP_BITS_MAX        5'h19

// ==========================================================
// field positions
`define FSWP_SR_WIP_BIT      0
`define FSWP_SR_WEL_BIT      1
`define FSWP_CR_DC_LO        6
`define FSWP_CR_DC_HI        7

// ==========================================================
// reset values: status all clear, drive strength 30 ohm code
`define FSWP_SR_RST          8'h00
`define FSWP_CR_RST          8'h07

// ==========================================================
// timing
`define FSWP_MCLK_PERIOD_NS  50
`define FSWP_TW_NS           40000
`define FSWP_TW_CYC          ((`FSWP_TW_NS + `FSWP_MCLK_PERIOD_NS - 1) / `FSWP_MCLK_PERIOD_NS)

`endif

/* core/fswp_pkg.sv */
// types of the status-write and write-protect block.
// assumes nothing beyond the tool's package support.
package fswp_pkg;

  // ==========================================================
  // status register, msb first
  typedef struct packed {
    logic       status_write_disable;
    logic       qe;
    logic [3:0] bp;
    logic       write_enable_latch;
    logic       write_in_progress;
  } fswp_status_t;

  // ==========================================================
  // configuration register, msb first
  typedef struct packed {
    logic [1:0] dc;
    logic       four_byte;
    logic       pbe;
    logic       tb;
    logic [2:0] drive_strength_sel;
  } fswp_config_t;

  // ==========================================================
  // read families that share a dummy-cycle column
  typedef enum logic [1:0] {
    FSWP_FAM_OUT,
    FSWP_FAM_DIO,
    FSWP_FAM_QIO
  } fswp_read_fam_t;

  // command engine state
  typedef enum logic {
    FSWP_IDLE,
    FSWP_WRITE
  } fswp_state_t;

endpackage

/* core/fswp_wtimer.sv */
// self-timed register write cycle timer.
// assumes start is a one-cycle pulse on mclk, never given while running.
`timescale 1ns/1ps
`default_nettype none
`include "fswp_cfg.svh"

module fswp_wtimer #(
  parameter int CYCLES = `FSWP_TW_CYC
) (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic start,
  output var  logic done_q
);

  localparam int W = $clog2(CYCLES + 1);

  logic [W-1:0] cnt_q;
  logic         run_q;

  // ==========================================================
  // countdown; done pulses one cycle after the count reaches zero
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_q  <= '0;
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        run_q <= 1'b1;
        cnt_q <= W'(CYCLES - 1);
      end else if (run_q) begin
        if (cnt_q == '0) begin
          run_q  <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire

/* verif/fswp_host_model.sv */
// serial host model: frames write-enable and write-status commands on the link.
// assumes each frame is started just after an mclk rising edge.
`timescale 1ns/1ps
`default_nettype none

module fswp_host_model (
  output var logic cs_n,
  output var logic sclk,
  output var logic si
);
  localparam int HALF_NS = 200; // 400 ns link clock

  // ==========================================================
  // idle: deselected, link clock parked low
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si   = 1'b0;
  end

  // ==========================================================
  // one frame, msb first, device samples on rising sclk
  task automatic frame(input logic [31:0] word, input int nbits);
    cs_n = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      si = word[i];
      #HALF_NS sclk = 1'b1;
      #HALF_NS sclk = 1'b0;
    end
    #HALF_NS cs_n = 1'b1;
    si = ~si; // released line must not keep showing the last bit
    #HALF_NS; // gap of more than 3 mclk before any next frame
  endtask
endmodule

`default_nettype wire

/* verif/flash_status_write_protect_tb_top.sv */
// self-checking bench of the status-write and write-protect block.
// assumes fswp_top, fswp_pkg and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "fswp_cfg.svh"

module flash_status_write_protect_tb_top;
  localparam int TW = 12; // short write time keeps the run brief
  localparam logic [6:0] OHMS [8] = '{7'h00, 7'h5A, 7'h3C, 7'h2D, 7'h00, 7'h14, 7'h0F, 7'h1E};
  localparam logic [3:0] DOUT [4] = '{4'h8, 4'h6, 4'h8, 4'hA};
  localparam logic [3:0] DDIO [4] = '{4'h4, 4'h6, 4'h8, 4'hA};
  localparam logic [3:0] DQIO [4] = '{4'h6, 4'h4, 4'h8, 4'hA};
  localparam logic [7:0] OP_WS = `FSWP_OP_WRITE_STATUS;

  logic                   mclk, nrst, cs_n, sclk, si, wp_n, four_wire, pe_req, pe_hit;
  fswp_pkg::fswp_status_t status_q;
  fswp_pkg::fswp_config_t config_q;
  logic                   hw_q, sw_q, quad_q, rej_q, pe_acc_q, pe_rej_q, res_q, rej_seen;
  logic [6:0]             ohms_q;
  logic [3:0]             d_out, d_dio, d_qio;
  int                     error_cnt, check_count;

  fswp_top #(.TW_CYCLES(TW)) i_dut (
    .mclk(mclk), .nrst(nrst), .cs_n(cs_n), .sclk(sclk), .si(si),
    .write_protect_n_io2(wp_n), .four_wire_cmd_mode(four_wire),
    .pe_req(pe_req), .pe_region_hit(pe_hit), .status_q(status_q), .config_q(config_q),
    .hardware_protect_mode_q(hw_q), .software_protect_mode_q(sw_q),
    .quad_cmds_enabled_q(quad_q), .write_status_cmd_reject_q(rej_q), .pe_accept_q(pe_acc_q),
    .pe_reject_q(pe_rej_q), .ods_ohms_q(ohms_q), .ods_reserved_q(res_q),
    .dummy_out_q(d_out), .dummy_dio_q(d_dio), .dummy_qio_q(d_qio));

  fswp_host_model i_host (.cs_n(cs_n), .sclk(sclk), .si(si));

  // ==========================================================
  // clock, and a sticky copy of the one-cycle refusal pulse
  always #25 mclk = ~mclk;
  // sampled mid-cycle so the pulse is seen while it stands
  always @(negedge mclk) begin
    if (rej_q === 1'b1) begin
      rej_seen = 1'b1;
    end
  end

  // ==========================================================
  // helpers
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  task automatic write_enable_cmd();
    i_host.frame({24'h000000, `FSWP_OP_WRITE_ENABLE}, 8);
    step(1);
  endtask

  task automatic write_status_cmd(input logic [31:0] word, input int nbits);
    rej_seen = 1'b0;
    i_host.frame(word, nbits);
    step(2);
  endtask

  // bounded wait for the timed write to finish
  task automatic wait_idle();
    for (int i = 0; i < 200 && status_q.write_in_progress !== 1'b0; i++) begin
      step(1);
    end
    if (status_q.write_in_progress !== 1'b0) begin
      error_cnt++;
      $display("MISMATCH busy flag expected 0 seen %b", status_q.write_in_progress);
      print_verdict();
    end else begin
      step(2);
    end
  endtask

  task automatic pin(input logic lvl);
    wp_n = lvl;
    step(6); // synchroniser plus decode
  endtask

  // returns while the one-cycle answer pulse still stands
  task automatic pe(input logic hit);
    pe_req = 1'b1;
    pe_hit = hit;
    step(1);
    pe_req = 1'b0;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    mclk = 1'b0; nrst = 1'b0; wp_n = 1'b0; four_wire = 1'b0;
    pe_req = 1'b0; pe_hit = 1'b0; rej_seen = 1'b0; error_cnt = 0; check_count = 0;
    step(6);
    nrst = 1'b1;
    step(4);
    chk("status", 16'h0000, status_q);
    chk("config", 16'h0007, config_q);
    chk("ohms", 16'h001E, ohms_q);
    chk("dummy", 16'h0846, {4'h0, d_out, d_dio, d_qio});
    chk("sw mode", 16'h0001, sw_q);
    // no latch yet: the write must be refused
    write_status_cmd({16'h0000, OP_WS, 8'hBC}, 16);
    chk("reject", 16'h0001, rej_seen);
    chk("status", 16'h0000, status_q);
    // pin low with disable bit 0 still writes; latch and busy bits ignored
    write_enable_cmd();
    chk("latch", 16'h0002, status_q);
    write_status_cmd({16'h0000, OP_WS, 8'hBF}, 16);
    chk("busy", 16'h0003, status_q);
    wait_idle();
    chk("status", 16'h00BC, status_q);
    step(4);
    chk("hw mode", 16'h0001, hw_q);
    // hardware mode: latch settable, write refused, bits frozen
    write_enable_cmd();
    write_status_cmd({16'h0000, OP_WS, 8'h00}, 16);
    chk("reject", 16'h0001, rej_seen);
    chk("status", 16'h00BE, status_q);
    pin(1'b1);
    chk("hw mode", 16'h0000, hw_q);
    chk("sw mode", 16'h0001, sw_q);
    // every drive strength and dummy code, pin held high
    for (int i = 0; i < 8; i++) begin
      write_enable_cmd();
      write_status_cmd({OP_WS, 8'h80, i[1:0], 3'b001, i[2:0]}, 24);
      wait_idle();
      chk("config", {8'h00, i[1:0], 3'b001, i[2:0]}, config_q);
      chk("ohms", {9'h000, OHMS[i]}, ohms_q);
      chk("reserved", {15'h0000, i == 0 || i == 4}, res_q);
      chk("dummy", {4'h0, DOUT[i%4], DDIO[i%4], DQIO[i%4]}, {4'h0, d_out, d_dio, d_qio});
      chk("status", 16'h0080, status_q);
    end
    // top/bottom bit cannot be cleared again
    write_enable_cmd();
    write_status_cmd({OP_WS, 8'h80, 8'h07}, 24);
    wait_idle();
    chk("config", 16'h000F, config_q);
    // chip select rising off a byte boundary
    write_enable_cmd();
    write_status_cmd({12'h000, OP_WS, 12'h000}, 20);
    chk("reject", 16'h0001, rej_seen);
    chk("status", 16'h0082, status_q);
    // quad enable masks the pin
    write_status_cmd({16'h0000, OP_WS, 8'hC0}, 16);
    wait_idle();
    pin(1'b0);
    chk("hw mode", 16'h0000, hw_q);
    chk("quad", 16'h0001, quad_q);
    // four-wire command mode masks the pin too
    pin(1'b1);
    four_wire = 1'b1;
    write_enable_cmd();
    write_status_cmd({16'h0000, OP_WS, 8'h80}, 16);
    wait_idle();
    pin(1'b0);
    chk("hw mode", 16'h0000, hw_q);
    four_wire = 1'b0;
    step(3);
    chk("hw mode", 16'h0001, hw_q);
    // program and erase against the protected region
    write_enable_cmd();
    pe(1'b1);
    chk("pe reject", 16'h0001, pe_rej_q);
    chk("status", 16'h0080, status_q);
    write_enable_cmd();
    pe(1'b0);
    chk("pe accept", 16'h0001, pe_acc_q);
    print_verdict();
  end
endmodule

`default_nettype wire
